//--- core/sctg_timing_guard.sv
// What this block does
// - Termination turns on write latency minus 2 clocks after request sampled high.
// - Termination turns off write latency minus 2 clocks after request drops.
// - Internal write starts write latency plus 4, or plus 2 with fixed chop.
// - Two-clock read preamble leaves high impedance one clock earlier.
`timescale 1ns/1ns
module sctg_timing_guard (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic link_ck,
  input wire logic termination_request,
  input wire logic write_cmd,
  input wire logic read_cmd,
  input wire logic fixed_burst_chop,
  input wire logic read_preamble_2ck,
  input wire sctg_pkg::sctg_lat_t column_write_latency,
  input wire sctg_pkg::sctg_lat_t additive_latency,
  input wire sctg_pkg::sctg_lat_t parity_latency,
  input wire sctg_pkg::sctg_lat_t cas_latency,
  output logic term_enable,
  output logic write_start,
  output logic strobe_lowz_start,
  output sctg_pkg::sctg_lat_t write_latency
);
  import sctg_pkg::*;

  // Pins cross into ref_clk through two flops; the third ck stage
  // only feeds the edge detector and never the first stage.
  // Reset level matches the idle-low clock, so no rise is invented
  logic [1:0] ck_sync_q, ck_sync_d;
  logic ck_prev_q, ck_prev_d;
  logic ck_rise;

  always_comb begin
    ck_sync_d = {ck_sync_q[0], link_ck};
    ck_prev_d = ck_sync_q[1];
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_sync_q <= 2'h0;
      ck_prev_q <= 1'b0;
    end else begin
      ck_sync_q <= ck_sync_d;
      ck_prev_q <= ck_prev_d;
    end
  end

  assign ck_rise = ck_sync_q[1] & ~ck_prev_q;

  // Command pins take the same two-flop path, so the level seen at
  // ck_rise is the one that stood at that command-clock rise
  logic [2:0] pin_m_q, pin_m_d;
  logic [2:0] pin_s_q, pin_s_d;

  always_comb begin
    pin_m_d = {read_cmd, write_cmd, termination_request};
    pin_s_d = pin_m_q;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_m_q <= 3'h0;
      pin_s_q <= 3'h0;
    end else begin
      pin_m_q <= pin_m_d;
      pin_s_q <= pin_s_d;
    end
  end

  // Read latency stays full width so the preamble back-off acts
  // before saturation
  logic [SUM_W-1:0] wrlat_sum;
  logic [SUM_W-1:0] rdlat_q, rdlat_d;
  sctg_lat_t wrlat_q, wrlat_d;

  always_comb begin
    wrlat_sum = SUM_W'(column_write_latency) + SUM_W'(additive_latency)
      + SUM_W'(parity_latency);
    wrlat_d = sctg_sat(wrlat_sum);
    rdlat_d = SUM_W'(cas_latency) + SUM_W'(additive_latency)
      + SUM_W'(parity_latency);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrlat_q <= '0;
      rdlat_q <= '0;
    end else begin
      wrlat_q <= wrlat_d;
      rdlat_q <= rdlat_d;
    end
  end

  // Delay settings; short latencies clamp at zero instead of wrapping.
  // A config change retimes events in flight: the lines hold levels,
  // not deadlines
  logic [SUM_W-1:0] term_lat;
  logic [SUM_W-1:0] wr_off;
  logic [SUM_W-1:0] wr_lat;
  logic [SUM_W-1:0] rd_pre;
  logic [SUM_W-1:0] rd_lat;
  sctg_lat_t term_dly_q, term_dly_d;
  sctg_lat_t wr_dly_q, wr_dly_d;
  sctg_lat_t rd_dly_q, rd_dly_d;

  always_comb begin
    if (SUM_W'(wrlat_q) > TERM_LAT_BACKOFF) begin
      term_lat = SUM_W'(wrlat_q) - TERM_LAT_BACKOFF;
    end else begin
      term_lat = '0;
    end
    case (fixed_burst_chop)
      1'b1: wr_off = WR_START_FIXED_CHOP;
      default: wr_off = WR_START_LONG;
    endcase
    wr_lat = SUM_W'(wrlat_q) + wr_off;
    case (read_preamble_2ck)
      1'b1: rd_pre = RD_PRE_TWO;
      default: rd_pre = RD_PRE_ONE;
    endcase
    if (rdlat_q > rd_pre) begin
      rd_lat = rdlat_q - rd_pre;
    end else begin
      rd_lat = '0;
    end
    term_dly_d = sctg_sat(term_lat);
    wr_dly_d = sctg_sat(wr_lat);
    rd_dly_d = sctg_sat(rd_lat);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      term_dly_q <= '0;
      wr_dly_q <= '0;
      rd_dly_q <= '0;
    end else begin
      term_dly_q <= term_dly_d;
      wr_dly_q <= wr_dly_d;
      rd_dly_q <= rd_dly_d;
    end
  end

  sctg_delay_if term_if ();
  sctg_delay_if wr_if ();
  sctg_delay_if rd_if ();

  // The requested level is delayed as a whole, so on and off share one
  // latency and a request shorter than it still gets its full width
  assign term_if.ck_rise = ck_rise;
  assign term_if.din = pin_s_q[0];
  assign term_if.delay = term_dly_q;
  assign wr_if.ck_rise = ck_rise;
  assign wr_if.din = pin_s_q[1];
  assign wr_if.delay = wr_dly_q;
  assign rd_if.ck_rise = ck_rise;
  assign rd_if.din = pin_s_q[2];
  assign rd_if.delay = rd_dly_q;

  // Depth 64 covers every saturated latency
  sctg_ck_delay #(.DEPTH(64)) u_term_dly (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .dl(term_if.line)
  );

  sctg_ck_delay #(.DEPTH(64)) u_wr_dly (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .dl(wr_if.line)
  );

  sctg_ck_delay #(.DEPTH(64)) u_rd_dly (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .dl(rd_if.line)
  );

  // Pulses last one ref_clk cycle at the chosen command-clock rise.
  // A line output settles one ref_clk after its rise, so the pulse
  // looks at it in the cycle after; reading it earlier adds a rise
  logic ck_rise_q, ck_rise_d;
  logic wr_pulse_q, wr_pulse_d;
  logic rd_pulse_q, rd_pulse_d;

  always_comb begin
    ck_rise_d = ck_rise;
    wr_pulse_d = ck_rise_q & wr_if.dout;
    rd_pulse_d = ck_rise_q & rd_if.dout;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_rise_q <= 1'b0;
      wr_pulse_q <= 1'b0;
      rd_pulse_q <= 1'b0;
    end else begin
      ck_rise_q <= ck_rise_d;
      wr_pulse_q <= wr_pulse_d;
      rd_pulse_q <= rd_pulse_d;
    end
  end

  // All outputs come straight from flops
  assign term_enable = term_if.dout;
  assign write_start = wr_pulse_q;
  assign strobe_lowz_start = rd_pulse_q;
  assign write_latency = wrlat_q;
endmodule : sctg_timing_guard

//--- shared/sctg_pkg.sv
package sctg_pkg;
  // Latency fields are in command-clock cycles
  localparam int unsigned LAT_W = 6;
  localparam int unsigned SUM_W = 8;
  localparam logic [SUM_W-1:0] TERM_LAT_BACKOFF = 8'h02;
  localparam logic [SUM_W-1:0] WR_START_LONG = 8'h04;
  localparam logic [SUM_W-1:0] WR_START_FIXED_CHOP = 8'h02;
  localparam logic [SUM_W-1:0] RD_PRE_ONE = 8'h01;
  localparam logic [SUM_W-1:0] RD_PRE_TWO = 8'h02;
  // Far-side limits, in command-clock cycles except SELECT_TO_CMD_MIN_PS, which is in picoseconds
  localparam int unsigned TERM_HOLD_LONG_1CK = 6;
  localparam int unsigned TERM_HOLD_LONG_2CK = 7;
  localparam int unsigned TERM_HOLD_SHORT_1CK = 4;
  localparam int unsigned TERM_HOLD_SHORT_2CK = 5;
  localparam int unsigned LEVEL_FIRST_EDGE_DELAY = 40;
  localparam int unsigned LEVEL_STROBE_DRIVE_DELAY = 25;
  localparam int unsigned HALF_RATE_SYNC_EXTRA = 4;
  localparam int unsigned SELECT_TO_CMD_MIN_CK = 3;
  localparam int unsigned SELECT_TO_CMD_MIN_PS = 3748;
  localparam logic [LAT_W-1:0] LAT_MAX = 6'h3f;

  typedef logic [LAT_W-1:0] sctg_lat_t;

  // Clamp a wide sum into the delay-line range
  function automatic sctg_lat_t sctg_sat(input logic [SUM_W-1:0] v);
    sctg_lat_t r;
    r = (v > {2'h0, LAT_MAX}) ? LAT_MAX : v[LAT_W-1:0];
    return r;
  endfunction : sctg_sat
endpackage : sctg_pkg

//--- shared/sctg_delay_if.sv
`timescale 1ns/1ns
interface sctg_delay_if;
  import sctg_pkg::*;
  logic ck_rise;
  logic din;
  sctg_lat_t delay;
  logic dout;
  modport user (output ck_rise, output din, output delay, input dout);
  modport line (input ck_rise, input din, input delay, output dout);
endinterface : sctg_delay_if

//--- core/sctg_ck_delay.sv
`timescale 1ns/1ns
module sctg_ck_delay #(
  parameter int unsigned DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  sctg_delay_if.line dl
);
  import sctg_pkg::*;

  logic [DEPTH-1:0] sr_q, sr_d;
  logic out_q, out_d;

  // Tap 0 holds the value sampled at the latest command-clock rise
  always_comb begin
    sr_d = sr_q;
    out_d = out_q;
    if (dl.ck_rise) begin
      sr_d = {sr_q[DEPTH-2:0], dl.din};
      out_d = sr_d[dl.delay];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sr_q <= '0;
      out_q <= 1'b0;
    end else begin
      sr_q <= sr_d;
      out_q <= out_d;
    end
  end

  assign dl.dout = out_q;
endmodule : sctg_ck_delay

//--- verification/sctg_ctrl_model.sv
`timescale 1ns/1ns
module sctg_ctrl_model (
  input wire logic [1:0] cmd_req,
  output logic link_ck,
  output logic write_cmd,
  output logic read_cmd,
  output logic termination_request
);
  import sctg_pkg::*;
  int hold = 0;
  int gap = 0;
  logic [1:0] cmd_q = 2'h0;
  logic take;
  // No power-down entry is ever driven
  // No reset exit, gear-down or sync sequence is driven
  // No refresh and no select-latency mode are used
  initial begin
    link_ck = 1'b0;
    #2;
    forever begin
      #62 link_ck = 1'b1;
      #63 link_ck = 1'b0;
    end
  end
  // One spacing counter stands for every command-to-command limit; it
  // loads the longest one, the leveling first-edge delay
  assign take = (|cmd_req) && (gap == 0);
  // Pins move on the falling edge so they sit flat across every rise
  always @(negedge link_ck) begin
    cmd_q <= take ? cmd_req : 2'h0;
    gap <= take ? int'(LEVEL_FIRST_EDGE_DELAY) :
      gap - int'(gap > 0);
    hold <= take ? int'(TERM_HOLD_LONG_2CK) :
      hold - int'(hold > 0);
  end
  assign {write_cmd, read_cmd} = cmd_q;
  assign termination_request = hold > 0;
endmodule : sctg_ctrl_model

//--- verification/sctg_chk.sv
`timescale 1ns/1ns
module sctg_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic link_ck,
  input wire logic term_enable,
  input wire logic write_start,
  input wire logic strobe_lowz_start
);
  logic [1:0] sy_q;
  logic [3:0] age_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Termination, write-start and lowz outputs may move only just after a link rise reaches this domain
  sequence near_link;
    age_q inside {[1:5]};
  endsequence
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      {sy_q, age_q} <= 6'h0f;
    else
      {sy_q, age_q} <= {sy_q[0], link_ck,
        ((sy_q == 2'h1) ? 4'h0 : age_q + 4'(age_q != 4'hf))};
  term_on_a: assert property ($rose(term_enable) |-> near_link)
    else $error("term on mistimed");
  term_off_a: assert property ($fell(term_enable) |-> near_link)
    else $error("term off mistimed");
  write_pulse_a: assert property (
    write_start |-> near_link ##1 !write_start)
    else $error("write start mistimed");
  lowz_pulse_a: assert property (
    strobe_lowz_start |-> near_link ##1 !strobe_lowz_start)
    else $error("strobe start mistimed");
endmodule : sctg_chk
bind sctg_timing_guard sctg_chk u_chk (.*);

//--- verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  import sctg_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, fixed_burst_chop = 1'b0;
  logic read_preamble_2ck = 1'b0;
  logic [1:0] cmd_req = 2'h0;
  sctg_lat_t column_write_latency = 6'h02, additive_latency = 6'h00;
  sctg_lat_t parity_latency = 6'h00, cas_latency = 6'h03, write_latency;
  logic link_ck, write_cmd, read_cmd, termination_request;
  logic term_enable, write_start, strobe_lowz_start;
  int rises, r0, wlat, rl, t_on, t_off, t_ws, t_lz, cyc;
  int miscompares, checks_done;
  sctg_timing_guard u_dut (.*);
  sctg_ctrl_model u_ctrl (.*);
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge link_ck) rises++;
  task automatic check(string what, logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("%0d checks, %0d miscompares", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // Each event is stamped with the count of link rises seen so far
  always @(negedge ref_clk) begin
    if (write_start) t_ws = rises;
    if (strobe_lowz_start) t_lz = rises;
    if (term_enable && t_on < 0) t_on = rises;
    if (!term_enable && t_on >= 0 && t_off < 0) t_off = rises;
    if (++cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    void'($urandom(42480));
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      column_write_latency = i ? 6'($urandom_range(20, 2)) : 6'h02;
      additive_latency = 6'($urandom_range(i, 0));
      parity_latency = 6'($urandom_range(i, 0) % 5);
      cas_latency = 6'($urandom_range(20, 3));
      {fixed_burst_chop, read_preamble_2ck} = {2{i[1]}};
      wlat = column_write_latency + additive_latency + parity_latency;
      rl = cas_latency + additive_latency + parity_latency - (i[1] ? 2 : 1);
      {t_on, t_off, t_ws, t_lz} = {4{32'hffffffff}};
      cmd_req = {!i[0], i[0]};
      @(negedge link_ck);
      @(negedge ref_clk);
      cmd_req = 2'h0;
      r0 = rises + 1;
      while (rises < r0 + 45) @(negedge ref_clk);
      check("wr_latency", write_latency, wlat);
      check("term_on", t_on, r0 + wlat - 2);
      check("term_off", t_off, r0 + wlat + 5);
      check("wr_start", t_ws, i[0] ? -1 : r0 + wlat + (i[1] ? 2 : 4));
      check("lowz", t_lz, i[0] ? r0 + rl : -1);
      $display("test %0d done", i);
    end
    summarize();
  end
endmodule : testbench
